//--- include/pfc_pkg.sv
// Constants, encodings and carrier types for the protection fault checker.
`default_nettype none
package pfc_pkg;
  localparam logic [7:0] VEC_INVALID_OP = 8'h06;
  localparam logic [7:0] VEC_NOT_PRESENT = 8'h0B;
  localparam logic [7:0] VEC_STACK = 8'h0C;
  localparam logic [7:0] VEC_GEN_PROT = 8'h0D;
  localparam logic [7:0] VEC_NONE = 8'h00;
  localparam logic [31:0] REAL_SEG_LIMIT = 32'h0000FFFF;
  localparam logic [1:0] PRIV_TOP = 2'h0;
  localparam logic [7:0] OP_ESC0F = 8'h0F;
  localparam logic [7:0] OP_FLUSH2 = 8'h09;
  localparam logic [7:0] OP_WAIT = 8'h9B;
  localparam logic [7:0] OP_EXCHANGE_ADD_OP_HI = 8'hC0;
  localparam logic [7:0] OP_EXCHANGE_ADD_OP_MASK = 8'hFE;
  localparam logic [7:0] OP_GRP6 = 8'h00;
  localparam logic [2:0] REG_VERIFY_WRITE_OP = 3'h5;
  localparam logic [3:0] CLK_FLUSH = 4'h4;
  localparam logic [3:0] CLK_WAIT = 4'h5;
  localparam logic [3:0] CLK_EXCHANGE_ADD_OP_RR = 4'h3;
  localparam logic [3:0] CLK_EXCHANGE_ADD_OP_MR = 4'h6;
  localparam logic [3:0] CLK_VERIFY_WRITE_OP_REG = 4'h9;
  localparam logic [3:0] CLK_VERIFY_WRITE_OP_HIT = 4'hA;
  localparam logic [3:0] CLK_VERIFY_WRITE_OP_MISS = 4'hC;
  localparam logic [3:0] CLK_MIN = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_COUNT = 4'h8;
  localparam int CTRL_COUNT_EN = 0;
  localparam int CTRL_CLR_COUNT = 1;
  localparam int STAT_SEEN = 8;
  localparam int STAT_BUSY = 9;
  localparam logic CTRL_RESET = 1'b1;

  typedef struct packed {
    logic [7:0] op0;
    logic [7:0] op1;
    logic [2:0] modrm_reg;
    logic modrm_is_reg;
    logic prot_only;
    logic priv0_only;
    logic io_priv_field_gated;
    logic auto_lock;
    logic dt_lock;
    logic smm_space;
    logic flag_reload;
    logic lmsw;
    logic mov_cr0;
    logic verify_sel;
    logic coproc;
    logic seg_load;
    logic far_xfer;
    logic mem_ref;
    logic cache_hit;
    logic [3:0] clocks;
  } pfc_insn_t;

  typedef struct packed {
    logic pe;
    logic [1:0] current_priv_level;
    logic [1:0] requested_priv_level;
    logic [1:0] descriptor_priv_level;
    logic [1:0] io_priv_field;
    logic seg_is_stack;
    logic seg_present;
    logic seg_priv_ok;
    logic access_ok;
    logic [31:0] off_start;
    logic [31:0] off_end;
    logic [31:0] seg_limit;
    logic other_cs;
    logic xfer_priv_ok;
    logic [31:0] target_off;
    logic [31:0] target_limit;
    logic old_if;
    logic [1:0] old_io_priv_field;
    logic old_vm;
    logic new_if;
    logic [1:0] new_io_priv_field;
    logic new_vm;
    logic src_pe;
  } pfc_ctx_t;

  typedef struct packed {
    logic fault;
    logic [7:0] vector;
    logic zf_clear;
  } pfc_result_t;

  typedef struct packed {
    logic if_flag;
    logic [1:0] io_priv_field;
    logic vm;
    logic pe;
  } pfc_state_t;
endpackage : pfc_pkg
`default_nettype wire

//--- core/pfc_checker.sv
// Protection fault checker with instruction timing and Avalon-MM registers.
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`default_nettype none
// How it works
// - Protected-only instruction in real mode: vector 6.
// - Real mode CS/DS/ES beyond FFFFH: vector 13.
// - Real mode stack beyond limit: vector 12.
// - Implicitly locked instructions of more than one clock assert bus lock.
// - Descriptor table accesses hold bus lock in instructions of more than one clock.
// - Protected operand limit/rights fault: 13, stack 12.
// - Segment load: privilege 13, absent 11/12.
// - Far transfer privilege violation raises 13.
// - Level-zero instructions fault 13 above 0.
// - I/O privileged instructions fault when level exceeds field.
// - Flag reload guards interrupt, I/O, 8086 fields.
// - Status word load never clears protection enable.
// - Verify privilege violation clears zero flag only.
// - Coprocessor operand faults 13, stack start 12.
// - Far transfer target beyond code limit: 13.
// - Management space accesses of instructions of more than one clock are non-cacheable.
// - Cache flush completes in 4 clocks.
// - Wait stalls on busy coprocessor, then 5 clocks.
// - Exchange-add takes 3 or 6 clocks.
// - Write verify protected-only, 9/10/12 clocks.
module pfc_checker
  import pfc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Instruction issue from the core.
  input wire logic insn_valid,
  output logic insn_ready,
  input wire pfc_insn_t insn,
  input wire pfc_ctx_t ctx,
  // Live core status.
  input wire logic fpu_busy,
  input wire logic dt_access,
  // Completion and results.
  output logic insn_done,
  output pfc_result_t result,
  output pfc_state_t arch_state,
  output logic bus_lock,
  output logic non_cacheable,
  // Avalon-MM register slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  typedef enum logic [1:0] {PFC_IDLE, PFC_WAIT_FPU, PFC_RUN} pfc_fsm_t;

  pfc_fsm_t state;
  logic [3:0] count;
  logic [3:0] next_count;
  logic held_lock;
  logic held_dt;
  logic held_smm;
  logic accept;
  logic ctrl_count_en;
  logic fault_seen;
  logic [7:0] last_vector;
  logic [31:0] fault_count;
  logic bus_ack;
  pfc_result_t next_result;

  function automatic logic is_verify_write_op(input pfc_insn_t i);
    return i.op0 == OP_ESC0F && i.op1 == OP_GRP6 && i.modrm_reg == REG_VERIFY_WRITE_OP;
  endfunction : is_verify_write_op

  function automatic pfc_result_t check(input pfc_insn_t i,
                                        input pfc_ctx_t c);
    pfc_result_t r;
    logic lim_bad;
    r = '{fault: 1'b0, vector: VEC_NONE, zf_clear: 1'b0};
    lim_bad = c.off_end > c.seg_limit;
    if (!c.pe) begin
      if (i.prot_only || is_verify_write_op(i)) begin
        r = '{fault: 1'b1, vector: VEC_INVALID_OP,
              zf_clear: 1'b0};
      end else if (i.mem_ref && c.seg_is_stack && lim_bad) begin
        r = '{fault: 1'b1, vector: VEC_STACK, zf_clear: 1'b0};
      end else if (i.mem_ref && !c.seg_is_stack &&
                   c.off_end > REAL_SEG_LIMIT) begin
        r = '{fault: 1'b1, vector: VEC_GEN_PROT, zf_clear: 1'b0};
      end
    end else if (i.priv0_only && c.current_priv_level > PRIV_TOP) begin
      r = '{fault: 1'b1, vector: VEC_GEN_PROT, zf_clear: 1'b0};
    end else if (i.io_priv_field_gated && c.current_priv_level > c.io_priv_field) begin
      r = '{fault: 1'b1, vector: VEC_GEN_PROT, zf_clear: 1'b0};
    end else if (i.verify_sel && !c.seg_priv_ok) begin
      r.zf_clear = 1'b1;
    end else if (i.seg_load && !c.seg_priv_ok) begin
      r = '{fault: 1'b1, vector: VEC_GEN_PROT, zf_clear: 1'b0};
    end else if (i.seg_load && !c.seg_present) begin
      r.fault = 1'b1;
      r.vector = c.seg_is_stack ? VEC_STACK : VEC_NOT_PRESENT;
    end else if (i.far_xfer && c.other_cs && !c.xfer_priv_ok) begin
      r = '{fault: 1'b1, vector: VEC_GEN_PROT, zf_clear: 1'b0};
    end else if (i.far_xfer && c.target_off > c.target_limit) begin
      r = '{fault: 1'b1, vector: VEC_GEN_PROT, zf_clear: 1'b0};
    end else if (i.coproc && c.seg_is_stack &&
                 c.off_start > c.seg_limit) begin
      r = '{fault: 1'b1, vector: VEC_STACK, zf_clear: 1'b0};
    end else if (i.coproc && !c.seg_is_stack &&
                 (lim_bad || !c.access_ok)) begin
      r = '{fault: 1'b1, vector: VEC_GEN_PROT, zf_clear: 1'b0};
    end else if (i.mem_ref && (lim_bad || !c.access_ok)) begin
      r.fault = 1'b1;
      r.vector = c.seg_is_stack ? VEC_STACK : VEC_GEN_PROT;
    end
    return r;
  endfunction : check

  function automatic logic [3:0] clocks_of(input pfc_insn_t i);
    logic [3:0] n;
    n = (i.clocks < CLK_MIN) ? CLK_MIN : i.clocks;
    if (i.op0 == OP_ESC0F && i.op1 == OP_FLUSH2) begin
      n = CLK_FLUSH;
    end else if (i.op0 == OP_WAIT) begin
      n = CLK_WAIT;
    end else if (i.op0 == OP_ESC0F &&
                 (i.op1 & OP_EXCHANGE_ADD_OP_MASK) == OP_EXCHANGE_ADD_OP_HI) begin
      n = i.modrm_is_reg ? CLK_EXCHANGE_ADD_OP_RR : CLK_EXCHANGE_ADD_OP_MR;
    end else if (is_verify_write_op(i)) begin
      n = i.modrm_is_reg ? CLK_VERIFY_WRITE_OP_REG :
          (i.cache_hit ? CLK_VERIFY_WRITE_OP_HIT : CLK_VERIFY_WRITE_OP_MISS);
    end
    return n;
  endfunction : clocks_of

  assign insn_ready = (state == PFC_IDLE);
  assign accept = insn_valid && insn_ready;
  assign next_result = check(insn, ctx);
  assign next_count = count - CLK_MIN;

  // A faulting instruction completes on the next edge; others are timed.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= PFC_IDLE;
      count <= CLK_MIN;
    end else begin
      case (state)
        PFC_IDLE: begin
          if (accept && !next_result.fault) begin
            count <= clocks_of(insn);
            if (insn.op0 == OP_WAIT && fpu_busy) begin
              state <= PFC_WAIT_FPU;
            end else if (clocks_of(insn) != CLK_MIN) begin
              state <= PFC_RUN;
            end
          end
        end
        PFC_WAIT_FPU: begin
          if (!fpu_busy) begin
            state <= PFC_RUN;
          end
        end
        PFC_RUN: begin
          count <= next_count;
          if (next_count == CLK_MIN) begin
            state <= PFC_IDLE;
          end
        end
        default: state <= PFC_IDLE;
      endcase
    end
  end

  // Completion pulse lands one clock after issue for a fault, else the instruction's clock count after issue, or after coprocessor release for a stalled wait.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      insn_done <= 1'b0;
    end else if (accept) begin
      insn_done <= next_result.fault || clocks_of(insn) == CLK_MIN;
    end else begin
      insn_done <= state == PFC_RUN && next_count == CLK_MIN;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      result <= '{fault: 1'b0, vector: VEC_NONE, zf_clear: 1'b0};
    end else if (accept) begin
      result <= next_result;
    end
  end

  // Attributes held for the lifetime of the instruction in flight.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      held_lock <= 1'b0;
      held_dt <= 1'b0;
      held_smm <= 1'b0;
    end else if (state == PFC_IDLE) begin
      held_lock <= accept && insn.auto_lock && !next_result.fault;
      held_dt <= accept && (insn.dt_lock || is_verify_write_op(insn)) &&
                 !next_result.fault;
      held_smm <= accept && insn.smm_space && !next_result.fault;
    end
  end

  // Lock is combinational from held state so a table access in a multi-clock instruction is never bare.
  assign bus_lock = (state != PFC_IDLE) &&
                    (held_lock || (held_dt && dt_access));
  assign non_cacheable = (state != PFC_IDLE) && held_smm;

  // Architectural fields that the checker polices on reload.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      arch_state <= '{if_flag: 1'b0, io_priv_field: PRIV_TOP, vm: 1'b0, pe: 1'b0};
    end else if (accept && !next_result.fault) begin
      if (insn.flag_reload) begin
        arch_state.if_flag <= (ctx.current_priv_level > ctx.io_priv_field) ? ctx.old_if
                                                   : ctx.new_if;
        arch_state.io_priv_field <= (ctx.current_priv_level == PRIV_TOP) ? ctx.new_io_priv_field
                                                 : ctx.old_io_priv_field;
        arch_state.vm <= (ctx.current_priv_level == PRIV_TOP) ? ctx.new_vm
                                               : ctx.old_vm;
      end
      if (insn.lmsw) begin
        arch_state.pe <= ctx.pe || ctx.src_pe;
      end else if (insn.mov_cr0) begin
        arch_state.pe <= ctx.src_pe;
      end else begin
        arch_state.pe <= ctx.pe;
      end
    end
  end

  // Statistics: the fault event wins over a software clear in one cycle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fault_seen <= 1'b0;
      last_vector <= VEC_NONE;
      fault_count <= 32'h00000000;
    end else if (accept && next_result.fault) begin
      fault_seen <= 1'b1;
      last_vector <= next_result.vector;
      if (ctrl_count_en) begin
        fault_count <= fault_count + 32'h00000001;
      end
    end else if (avs_write && bus_ack && avs_address == ADDR_CTRL &&
                 avs_writedata[CTRL_CLR_COUNT]) begin
      fault_seen <= 1'b0;
      fault_count <= 32'h00000000;
    end
  end

  // One wait state per access; the answer is registered.
  assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read || avs_write) && !bus_ack;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_count_en <= CTRL_RESET;
    end else if (avs_write && bus_ack && avs_address == ADDR_CTRL) begin
      ctrl_count_en <= avs_writedata[CTRL_COUNT_EN];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !bus_ack) begin
      if (avs_address == ADDR_CTRL) begin
        avs_readdata <= {31'h00000000, ctrl_count_en};
      end else if (avs_address == ADDR_STATUS) begin
        avs_readdata <= {22'h000000, state != PFC_IDLE, fault_seen,
                         last_vector};
      end else if (avs_address == ADDR_COUNT) begin
        avs_readdata <= fault_count;
      end else begin
        avs_readdata <= 32'h00000000;
      end
    end
  end

  sequence s_flush_issue;
    accept && !next_result.fault && insn.op0 == OP_ESC0F &&
      insn.op1 == OP_FLUSH2;
  endsequence
  sequence s_fpu_released;
    state == PFC_WAIT_FPU && !fpu_busy;
  endsequence
  property p_real_invalid;
    @(posedge core_clk) disable iff (rst)
      accept && !ctx.pe && insn.prot_only |=>
        insn_done && result.fault && result.vector == VEC_INVALID_OP;
  endproperty
  a_real_invalid: assert property (p_real_invalid)
    else $error("Protected-only op in real mode did not give vector 6.");
  property p_real_limit;
    @(posedge core_clk) disable iff (rst)
      accept && !ctx.pe && !insn.prot_only && !is_verify_write_op(insn) &&
        insn.mem_ref && !ctx.seg_is_stack &&
        ctx.off_end > REAL_SEG_LIMIT |=> result.vector == VEC_GEN_PROT;
  endproperty
  a_real_limit: assert property (p_real_limit)
    else $error("Real mode offset beyond FFFFH did not give vector 13.");
  property p_flush_time;
    @(posedge core_clk) disable iff (rst)
      s_flush_issue |=> !insn_done [*3] ##1 insn_done;
  endproperty
  a_flush_time: assert property (p_flush_time)
    else $error("Cache flush did not complete in 4 clocks.");
  property p_wait_time;
    @(posedge core_clk) disable iff (rst)
      s_fpu_released |=> !insn_done [*4] ##1 insn_done;
  endproperty
  a_wait_time: assert property (p_wait_time)
    else $error("Coprocessor wait did not finish 5 clocks after release.");
  property p_wait_stall;
    @(posedge core_clk) disable iff (rst)
      state == PFC_WAIT_FPU && fpu_busy |=> state == PFC_WAIT_FPU;
  endproperty
  a_wait_stall: assert property (p_wait_stall)
    else $error("Coprocessor wait left while coprocessor busy.");

  property p_auto_lock;
    @(posedge core_clk) disable iff (rst)
      accept && insn.auto_lock && !next_result.fault &&
        clocks_of(insn) > CLK_MIN && insn.op0 != OP_WAIT |=> bus_lock;
  endproperty
  a_auto_lock: assert property (p_auto_lock)
    else $error("Implicitly locked instruction did not assert bus lock.");

  property p_priv0;
    @(posedge core_clk) disable iff (rst)
      accept && ctx.pe && insn.priv0_only && ctx.current_priv_level != PRIV_TOP |=>
        result.fault && result.vector == VEC_GEN_PROT;
  endproperty
  a_priv0: assert property (p_priv0)
    else $error("Level-zero instruction above level 0 did not fault.");

  property p_lmsw_pe;
    @(posedge core_clk) disable iff (rst)
      accept && !next_result.fault && insn.lmsw && ctx.pe |=> arch_state.pe;
  endproperty
  a_lmsw_pe: assert property (p_lmsw_pe)
    else $error("Status word load cleared protection enable.");

  property p_verify_no_fault;
    @(posedge core_clk) disable iff (rst)
      accept && ctx.pe && insn.verify_sel && !ctx.seg_priv_ok &&
        !insn.priv0_only && !insn.io_priv_field_gated |=>
        !result.fault && result.zf_clear;
  endproperty
  a_verify_no_fault: assert property (p_verify_no_fault)
    else $error("Verify privilege violation raised a fault.");
  property p_smm_nc;
    @(posedge core_clk) disable iff (rst)
      accept && insn.smm_space && !next_result.fault &&
        clocks_of(insn) != CLK_MIN |=> non_cacheable;
  endproperty
  a_smm_nc: assert property (p_smm_nc)
    else $error("Management space access was cacheable.");
endmodule : pfc_checker
`default_nettype wire

//--- bench/pfc_checker_tb.sv
// Self-checking testbench for the protection fault checker.
`default_nettype none
module pfc_checker_tb
  import pfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic insn_valid = 1'b0;
  logic insn_ready;
  pfc_insn_t insn = '0;
  pfc_ctx_t ctx = '0;
  logic fpu_busy = 1'b0;
  logic dt_access = 1'b0;
  logic insn_done;
  pfc_result_t result;
  pfc_state_t arch_state;
  logic bus_lock;
  logic non_cacheable;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int mismatches = 0;
  int samples_checked = 0;
  int nfault = 0;
  logic [7:0] last_vec = 8'h00;
  logic lock_c1;
  logic nc_c1;
  logic [31:0] rd;
  pfc_insn_t i;
  pfc_ctx_t c;

  always #50 core_clk = ~core_clk;

  pfc_checker dut_u (
    .core_clk(core_clk), .rst(rst), .insn_valid(insn_valid),
    .insn_ready(insn_ready), .insn(insn), .ctx(ctx), .fpu_busy(fpu_busy),
    .dt_access(dt_access), .insn_done(insn_done), .result(result),
    .arch_state(arch_state), .bus_lock(bus_lock),
    .non_cacheable(non_cacheable), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  task automatic stop_test;
    $display("checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  function automatic pfc_insn_t op(input logic [7:0] b0,
      input logic [7:0] b1, input logic [2:0] r, input logic isreg,
      input logic hit);
    pfc_insn_t n;
    n = '0;
    n.op0 = b0;
    n.op1 = b1;
    n.modrm_reg = r;
    n.modrm_is_reg = isreg;
    n.cache_hit = hit;
    return n;
  endfunction : op

  // A context that breaks nothing, so each case flips only its own cause.
  function automatic pfc_ctx_t base(input logic pe);
    pfc_ctx_t n;
    n = '0;
    n.pe = pe;
    n.src_pe = pe;
    n.seg_present = 1'b1;
    n.seg_priv_ok = 1'b1;
    n.access_ok = 1'b1;
    n.xfer_priv_ok = 1'b1;
    n.seg_limit = 32'h0000FFFF;
    n.target_limit = 32'h0000FFFF;
    return n;
  endfunction : base

  task automatic avs_xfer(input logic wr, input logic [3:0] a,
      input logic [31:0] wd, output logic [31:0] data);
    @(posedge core_clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    data = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : avs_xfer

  // Cycles are counted from the accept edge to the done pulse.
  task automatic run(input pfc_insn_t ti, input pfc_ctx_t tc, output int cyc);
    @(posedge core_clk);
    insn_valid <= 1'b1;
    insn <= ti;
    ctx <= tc;
    do begin
      @(posedge core_clk);
    end while (insn_ready !== 1'b1);
    insn_valid <= 1'b0;
    cyc = 0;
    do begin
      @(posedge core_clk);
      cyc++;
      if (cyc == 1) begin
        lock_c1 = bus_lock;
        nc_c1 = non_cacheable;
      end
    end while (insn_done !== 1'b1);
  endtask : run

  task automatic try_insn(input pfc_insn_t ti, input pfc_ctx_t tc,
      input logic [7:0] vec, input logic zf, input int clk);
    int cyc;
    run(ti, tc, cyc);
    check(32'(cyc), 32'(clk));
    check({22'h0, result}, {22'h0, vec !== VEC_NONE, vec, zf});
    if (vec !== VEC_NONE) begin
      nfault++;
      last_vec = vec;
    end
  endtask : try_insn

  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    avs_xfer(1'b0, ADDR_CTRL, 32'h0, rd);
    check(rd, 32'h00000001);
    $display("test reset done");

    i = op(8'h90, 8'h00, 3'h0, 1'b1, 1'b1);
    c = base(1'b0);
    i.prot_only = 1'b1;
    try_insn(i, c, VEC_INVALID_OP, 1'b0, 1);
    i = op(8'h90, 8'h00, 3'h0, 1'b1, 1'b1);
    i.mem_ref = 1'b1;
    c.seg_limit = 32'hFFFFFFFF;
    c.off_end = 32'h0000FFFF;
    try_insn(i, c, VEC_NONE, 1'b0, 1);
    c.off_end = 32'h00010000;
    try_insn(i, c, VEC_GEN_PROT, 1'b0, 1);
    c = base(1'b0);
    c.seg_is_stack = 1'b1;
    c.seg_limit = 32'h00000FFF;
    c.off_end = 32'h00001000;
    try_insn(i, c, VEC_STACK, 1'b0, 1);
    c.pe = 1'b1;
    try_insn(i, c, VEC_STACK, 1'b0, 1);
    c = base(1'b1);
    c.access_ok = 1'b0;
    try_insn(i, c, VEC_GEN_PROT, 1'b0, 1);
    i.coproc = 1'b1;
    try_insn(i, c, VEC_GEN_PROT, 1'b0, 1);
    c = base(1'b1);
    c.seg_is_stack = 1'b1;
    c.off_start = 32'h00010000;
    c.off_end = 32'h00010001;
    try_insn(i, c, VEC_STACK, 1'b0, 1);
    $display("test operand limits done");

    i = op(8'h90, 8'h00, 3'h0, 1'b1, 1'b1);
    i.seg_load = 1'b1;
    c = base(1'b1);
    c.seg_priv_ok = 1'b0;
    try_insn(i, c, VEC_GEN_PROT, 1'b0, 1);
    c = base(1'b1);
    c.seg_present = 1'b0;
    try_insn(i, c, VEC_NOT_PRESENT, 1'b0, 1);
    c.seg_is_stack = 1'b1;
    try_insn(i, c, VEC_STACK, 1'b0, 1);
    i = op(8'h90, 8'h00, 3'h0, 1'b1, 1'b1);
    i.far_xfer = 1'b1;
    c = base(1'b1);
    c.other_cs = 1'b1;
    c.xfer_priv_ok = 1'b0;
    try_insn(i, c, VEC_GEN_PROT, 1'b0, 1);
    c = base(1'b1);
    c.target_off = 32'h00010000;
    try_insn(i, c, VEC_GEN_PROT, 1'b0, 1);
    i = op(8'h90, 8'h00, 3'h0, 1'b1, 1'b1);
    i.priv0_only = 1'b1;
    c = base(1'b1);
    try_insn(i, c, VEC_NONE, 1'b0, 1);
    c.current_priv_level = 2'h1;
    try_insn(i, c, VEC_GEN_PROT, 1'b0, 1);
    i = op(8'h90, 8'h00, 3'h0, 1'b1, 1'b1);
    i.io_priv_field_gated = 1'b1;
    c.current_priv_level = 2'h2;
    c.io_priv_field = 2'h2;
    try_insn(i, c, VEC_NONE, 1'b0, 1);
    c.current_priv_level = 2'h3;
    try_insn(i, c, VEC_GEN_PROT, 1'b0, 1);
    i = op(8'h90, 8'h00, 3'h0, 1'b1, 1'b1);
    i.verify_sel = 1'b1;
    c = base(1'b1);
    c.seg_priv_ok = 1'b0;
    try_insn(i, c, VEC_NONE, 1'b1, 1);
    $display("test privilege done");

    i = op(8'h90, 8'h00, 3'h0, 1'b1, 1'b1);
    i.flag_reload = 1'b1;
    c = base(1'b1);
    c.current_priv_level = 2'h3;
    c.io_priv_field = 2'h1;
    c.old_if = 1'b1;
    c.old_io_priv_field = 2'h1;
    c.new_io_priv_field = 2'h3;
    c.new_vm = 1'b1;
    try_insn(i, c, VEC_NONE, 1'b0, 1);
    check(32'(arch_state), 32'(5'b1_01_0_1));
    c.current_priv_level = 2'h0;
    try_insn(i, c, VEC_NONE, 1'b0, 1);
    check(32'(arch_state), 32'(5'b0_11_1_1));
    i = op(8'h90, 8'h00, 3'h0, 1'b1, 1'b1);
    i.lmsw = 1'b1;
    c = base(1'b1);
    c.src_pe = 1'b0;
    try_insn(i, c, VEC_NONE, 1'b0, 1);
    check(32'(arch_state.pe), 32'h1);
    i.lmsw = 1'b0;
    i.mov_cr0 = 1'b1;
    try_insn(i, c, VEC_NONE, 1'b0, 1);
    check(32'(arch_state.pe), 32'h0);
    $display("test flags done");

    i = op(8'h90, 8'h00, 3'h0, 1'b1, 1'b1);
    i.clocks = 4'h3;
    try_insn(i, base(1'b1), VEC_NONE, 1'b0, 3);
    check({30'h0, lock_c1, nc_c1}, 32'h0);
    i.auto_lock = 1'b1;
    try_insn(i, base(1'b1), VEC_NONE, 1'b0, 3);
    check(32'(lock_c1), 32'h1);
    i.auto_lock = 1'b0;
    i.dt_lock = 1'b1;
    @(posedge core_clk);
    dt_access <= 1'b1;
    try_insn(i, base(1'b1), VEC_NONE, 1'b0, 3);
    check(32'(lock_c1), 32'h1);
    @(posedge core_clk);
    dt_access <= 1'b0;
    i.dt_lock = 1'b0;
    i.smm_space = 1'b1;
    try_insn(i, base(1'b1), VEC_NONE, 1'b0, 3);
    check(32'(nc_c1), 32'h1);
    $display("test lock and cache done");

    for (int m = 0; m < 2; m++) begin
      try_insn(op(OP_ESC0F, OP_FLUSH2, 3'h0, 1'b1, 1'b1), base(m[0]),
        VEC_NONE, 1'b0, 4);
      try_insn(op(OP_ESC0F, OP_EXCHANGE_ADD_OP_HI, 3'h0, 1'b1, 1'b1), base(m[0]),
        VEC_NONE, 1'b0, 3);
      try_insn(op(OP_ESC0F, 8'hC1, 3'h2, 1'b0, 1'b0), base(m[0]),
        VEC_NONE, 1'b0, 6);
    end
    try_insn(op(OP_ESC0F, OP_GRP6, REG_VERIFY_WRITE_OP, 1'b1, 1'b1), base(1'b1),
      VEC_NONE, 1'b0, 9);
    try_insn(op(OP_ESC0F, OP_GRP6, REG_VERIFY_WRITE_OP, 1'b0, 1'b1), base(1'b1),
      VEC_NONE, 1'b0, 10);
    try_insn(op(OP_ESC0F, OP_GRP6, REG_VERIFY_WRITE_OP, 1'b0, 1'b0), base(1'b1),
      VEC_NONE, 1'b0, 12);
    try_insn(op(OP_ESC0F, OP_GRP6, REG_VERIFY_WRITE_OP, 1'b1, 1'b1), base(1'b0),
      VEC_INVALID_OP, 1'b0, 1);
    try_insn(op(OP_WAIT, 8'h00, 3'h0, 1'b1, 1'b1), base(1'b1),
      VEC_NONE, 1'b0, 5);
    // The busy line drops three edges after accept, so six more follow.
    @(posedge core_clk);
    fpu_busy <= 1'b1;
    fork
      try_insn(op(OP_WAIT, 8'h00, 3'h0, 1'b1, 1'b0), base(1'b1),
        VEC_NONE, 1'b0, 9);
      begin
        repeat (5) @(posedge core_clk);
        fpu_busy <= 1'b0;
      end
    join
    $display("test timing done");

    avs_xfer(1'b0, ADDR_COUNT, 32'h0, rd);
    check(rd, 32'(nfault));
    avs_xfer(1'b0, ADDR_STATUS, 32'h0, rd);
    check(rd, {24'h001, last_vec});
    avs_xfer(1'b1, ADDR_CTRL, 32'h00000002, rd);
    avs_xfer(1'b0, ADDR_COUNT, 32'h0, rd);
    check(rd, 32'h0);
    avs_xfer(1'b0, ADDR_STATUS, 32'h0, rd);
    check(rd & 32'h00000300, 32'h0);
    avs_xfer(1'b1, 4'hC, 32'hFFFFFFFF, rd);
    avs_xfer(1'b0, 4'hC, 32'h0, rd);
    check(rd, 32'h0);
    avs_xfer(1'b0, ADDR_CTRL, 32'h0, rd);
    check(rd, 32'h0);
    $display("test registers done");
    stop_test();
  end
endmodule : pfc_checker_tb
`default_nettype wire
